// ### include/nsl_regs.vh
// Purpose: Constants for the network status indicator driver
// Assumes: 20 MHz system clock
// Notes:   Definitions only
`ifndef NSL_REGS_VH
`define NSL_REGS_VH
`define NSL_CLK_HZ 32'h01312D00
`define NSL_BLINK_SLOW_HZ 8'h0A
`define NSL_BLINK_FAST_HZ 8'h14
// Half period of each blink, in clock cycles (toggle rate is twice the blink rate)
// Sized to the blinker counter so no bits are dropped at the parameter
// Slow: clock / (2 * 10 Hz) cycles
`define NSL_SLOW_HALF_CYC 24'h0F4240
// Fast: clock / (2 * 20 Hz) cycles
`define NSL_FAST_HALF_CYC 24'h07A120
`define NSL_HOLD_MS 8'h64
// Hold: 100 ms of clock cycles
`define NSL_HOLD_CYC 24'h1E8480
// Edges after reset release before the strap is trusted
`define NSL_SETTLE_CYC 2'h3
`define NSL_CNT_W 24
`define NSL_MODE_THREE 1'b0
`define NSL_MODE_FOUR 1'b1
`endif

// ### rtl/nsl_blinker.v
// Purpose: Hold-stretched square wave blinker for one indicator
// Assumes: trig_in is synchronous to clk_in
// Notes:   Half period and hold counts come from the instantiating module
`timescale 1ns/10ps
`default_nettype none
module nsl_blinker #(
    parameter [23:0] HALF_CYC = 24'h0F4240,
    parameter [23:0] HOLD_CYC = 24'h1E8480
) (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Trigger
    input wire trig_in,
    // Result
    output wire active_out,
    output wire wave_out
);
    reg [23:0] half_ff;
    reg [23:0] hold_ff;
    reg wave_ff;
    wire busy;
    assign busy = trig_in | (hold_ff != 24'h000000);
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            half_ff <= 24'h000000;
            hold_ff <= 24'h000000;
            wave_ff <= 1'b0;
        end else begin
            if (trig_in) begin
                hold_ff <= HOLD_CYC;
            end else if (hold_ff != 24'h000000) begin
                hold_ff <= hold_ff - 24'h000001;
            end
            if (!busy) begin
                // Restart dark so each burst begins with a full off phase
                half_ff <= 24'h000000;
                wave_ff <= 1'b0;
            end else if (half_ff == HALF_CYC - 24'h000001) begin
                half_ff <= 24'h000000;
                wave_ff <= ~wave_ff;
            end else begin
                half_ff <= half_ff + 24'h000001;
            end
        end
    end
    assign active_out = busy;
    assign wave_out = wave_ff;
endmodule // nsl_blinker
`default_nettype wire

// ### rtl/nsl_led_driver.v
// Purpose: Network status indicator driver, three or four lamp display
// Assumes: Status inputs come from MAC/transceiver logic on clk_in
// Notes:   Outputs are active high (lamp lit); board inverts if needed
//          Mode strap is taken once per reset; later moves are ignored
//          Blink holds run 100 ms past the last triggering event
`timescale 1ns/10ps
`default_nettype none
`include "nsl_regs.vh"
// Operation
// - Two display modes: three or four lamps
// - Three-lamp: speed lamp lit at 100M
// - Three-lamp: link/activity steady when link idle
// - Three-lamp: link/activity blinks 10Hz on traffic
// - Three-lamp: duplex steady, collision blinks 20Hz
// - Four-lamp: 100M link lamp
// - Four-lamp: 10M link lamp
// - Four-lamp: activity lamp blinks 10Hz
// - Four-lamp: duplex steady, collision blinks 20Hz
module nsl_led_driver (
    // Clock and reset
    input wire clk_in,
    input wire reset_in,
    // Configuration strap
    input wire four_led_mode_in,
    // Status from MAC and transceiver
    input wire link_ok_in,
    input wire speed_100_in,
    input wire full_duplex_in,
    input wire rx_active_in,
    input wire tx_active_in,
    input wire collision_in,
    // Indicator lamps
    output reg led0_out,
    output reg led1_out,
    output reg duplex_collision_indicator_out,
    output reg led3_out,
    output wire mode_four_out
);
    // ------------------------------------------------------------
    // Mode capture
    // ------------------------------------------------------------
    // The strap comes from a pin, so it passes two stages first. The
    // mode is taken once, after the stages have filled with the real
    // strap level; taking it at the first edge would only ever see the
    // reset value of the second stage.
    localparam [2:0] ST_SETTLE = 3'h1;
    localparam [2:0] ST_TAKE = 3'h2;
    localparam [2:0] ST_RUN = 3'h4;
    reg strap_s1_ff;
    reg strap_s2_ff;
    reg [1:0] settle_ff;
    reg [1:0] nxt_settle;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg mode_ff;
    reg nxt_mode;
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            strap_s1_ff <= 1'b0;
            strap_s2_ff <= 1'b0;
        end else begin
            strap_s1_ff <= four_led_mode_in;
            strap_s2_ff <= strap_s1_ff;
        end
    end
    always @* begin
        nxt_state = state_ff;
        nxt_settle = settle_ff;
        nxt_mode = mode_ff;
        case (state_ff)
            ST_SETTLE: begin
                if (settle_ff == `NSL_SETTLE_CYC) begin
                    nxt_state = ST_TAKE;
                end else begin
                    nxt_settle = settle_ff + 2'h1;
                end
            end
            ST_TAKE: begin
                nxt_mode = strap_s2_ff;
                nxt_state = ST_RUN;
            end
            ST_RUN: begin
                // Later strap moves are ignored until the next reset
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_SETTLE;
                nxt_settle = 2'h0;
            end
        endcase
    end
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= ST_SETTLE;
            settle_ff <= 2'h0;
            mode_ff <= `NSL_MODE_THREE;
        end else begin
            state_ff <= nxt_state;
            settle_ff <= nxt_settle;
            mode_ff <= nxt_mode;
        end
    end
    assign mode_four_out = mode_ff;

    // ------------------------------------------------------------
    // Activity triggers
    // ------------------------------------------------------------
    // Collision-free transmit only counts as activity in three-lamp mode
    wire act3_trig;
    wire act4_trig;
    assign act3_trig = link_ok_in & (rx_active_in | (tx_active_in & ~collision_in));
    assign act4_trig = rx_active_in | tx_active_in;

    // ------------------------------------------------------------
    // Blink generators
    // ------------------------------------------------------------
    // Three-lamp and four-lamp activity need separate blinkers because
    // their triggers differ; a shared one would blink on collided sends
    wire act3_busy;
    wire act3_wave;
    wire act4_busy;
    wire act4_wave;
    wire col_busy;
    wire col_wave;
    nsl_blinker #(
        .HALF_CYC(`NSL_SLOW_HALF_CYC),
        .HOLD_CYC(`NSL_HOLD_CYC)
    ) u_act3 (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .trig_in(act3_trig),
        .active_out(act3_busy),
        .wave_out(act3_wave)
    );
    nsl_blinker #(
        .HALF_CYC(`NSL_SLOW_HALF_CYC),
        .HOLD_CYC(`NSL_HOLD_CYC)
    ) u_act4 (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .trig_in(act4_trig),
        .active_out(act4_busy),
        .wave_out(act4_wave)
    );
    nsl_blinker #(
        .HALF_CYC(`NSL_FAST_HALF_CYC),
        .HOLD_CYC(`NSL_HOLD_CYC)
    ) u_col (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .trig_in(collision_in),
        .active_out(col_busy),
        .wave_out(col_wave)
    );

    // ------------------------------------------------------------
    // Three-lamp view
    // ------------------------------------------------------------
    reg view3_speed;
    reg view3_link;
    always @* begin
        view3_speed = speed_100_in;
        if (!link_ok_in) begin
            // No link: dark, even while an old activity hold runs out
            view3_link = 1'b0;
        end else if (act3_busy) begin
            view3_link = act3_wave;
        end else begin
            view3_link = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Four-lamp view
    // ------------------------------------------------------------
    reg view4_fast;
    reg view4_slow;
    reg view4_act;
    always @* begin
        view4_fast = link_ok_in & speed_100_in;
        view4_slow = link_ok_in & ~speed_100_in;
        // Gated by the hold, so the lamp rests dark between bursts
        view4_act = act4_busy & act4_wave;
    end

    // ------------------------------------------------------------
    // Lamp registers
    // ------------------------------------------------------------
    // Registered so the lamp pins never glitch when the mode or a
    // status input changes between edges
    reg nxt_led0;
    reg nxt_led1;
    reg nxt_dup;
    reg nxt_led3;
    always @* begin
        // Collision blinking overrides the steady duplex level
        nxt_dup = col_busy ? col_wave : full_duplex_in;
        if (mode_ff == `NSL_MODE_FOUR) begin
            nxt_led0 = view4_fast;
            nxt_led1 = view4_slow;
            nxt_led3 = view4_act;
        end else begin
            nxt_led0 = view3_speed;
            nxt_led1 = view3_link;
            // The fourth lamp has no job in three-lamp mode
            nxt_led3 = 1'b0;
        end
    end
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            led0_out <= 1'b0;
            led1_out <= 1'b0;
            duplex_collision_indicator_out <= 1'b0;
            led3_out <= 1'b0;
        end else begin
            led0_out <= nxt_led0;
            led1_out <= nxt_led1;
            duplex_collision_indicator_out <= nxt_dup;
            led3_out <= nxt_led3;
        end
    end
endmodule // nsl_led_driver
`default_nettype wire

// ### verification/nsl_led_sva.sv
// Purpose: Lamp driver checks
// Assumes: Mode is taken within a few cycles of each reset release
// Notes: Seen flags mark first traffic and collision since reset
`timescale 1ns/10ps
`default_nettype none
module nsl_led_sva (
    input wire logic clk_in, reset_in, four_led_mode_in, link_ok_in, speed_100_in, full_duplex_in,
    input wire logic rx_active_in, tx_active_in, collision_in, led0_out, led1_out,
    input wire logic duplex_collision_indicator_out, led3_out, mode_four_out
);
    logic act_seen_ff, col_seen_ff;
    logic [3:0] since_rst_ff;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            act_seen_ff <= 1'h0;
            col_seen_ff <= 1'h0;
            since_rst_ff <= 4'h0;
        end else begin
            act_seen_ff <= act_seen_ff | rx_active_in | tx_active_in;
            col_seen_ff <= col_seen_ff | collision_in;
            if (since_rst_ff != 4'hF) begin
                since_rst_ff <= since_rst_ff + 4'h1;
            end
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_mode_held: assert property (
        since_rst_ff == 4'hF |-> $stable(mode_four_out)) else $error("mode moved");
    a_mode_wait: assert property (
        since_rst_ff < 4'h4 |-> !mode_four_out) else $error("mode early");
    a_fast_link: assert property (
        mode_four_out |=> led0_out == $past(link_ok_in && speed_100_in)) else $error("fast link");
    a_slow_link: assert property (
        mode_four_out |=> led1_out == $past(link_ok_in && !speed_100_in)) else $error("slow link");
    a_four_act: assert property (
        mode_four_out && !act_seen_ff && (rx_active_in || tx_active_in) |=> !led3_out [*8]) else $error("act4 start");
    a_four_idle: assert property (
        mode_four_out && !act_seen_ff && !rx_active_in && !tx_active_in |=> !led3_out) else $error("act4 idle");
    a_three_no_act: assert property (!mode_four_out |-> !led3_out) else $error("lamp3 lit");
    a_speed_lamp: assert property (!mode_four_out |=> led0_out == $past(speed_100_in)) else $error("speed");
    a_link_steady: assert property (
        !mode_four_out && !act_seen_ff && !rx_active_in && !tx_active_in
        |=> led1_out == $past(link_ok_in)) else $error("link lamp");
    a_link_gate: assert property (!mode_four_out && !link_ok_in |=> !led1_out) else $error("no link");
    a_act_dark: assert property (
        !mode_four_out && link_ok_in && !act_seen_ff && !collision_in
        && (rx_active_in || tx_active_in) |=> !led1_out [*8]) else $error("act start");
    a_duplex_lamp: assert property (
        !col_seen_ff && !collision_in
        |=> duplex_collision_indicator_out == $past(full_duplex_in)) else $error("duplex");
    a_col_dark: assert property (
        !col_seen_ff && collision_in
        |=> !duplex_collision_indicator_out [*8]) else $error("col start");
    c_act: cover property (link_ok_in && rx_active_in);
    c_four: cover property (mode_four_out && (rx_active_in || tx_active_in));
    c_col: cover property (collision_in && full_duplex_in);
    c_fdx: cover property (full_duplex_in && speed_100_in);
endmodule // nsl_led_sva
bind nsl_led_driver nsl_led_sva u_sva (.clk_in(clk_in), .reset_in(reset_in), .four_led_mode_in(four_led_mode_in),
    .link_ok_in(link_ok_in), .speed_100_in(speed_100_in), .full_duplex_in(full_duplex_in),
    .rx_active_in(rx_active_in), .tx_active_in(tx_active_in), .collision_in(collision_in), .led0_out(led0_out),
    .led1_out(led1_out), .duplex_collision_indicator_out(duplex_collision_indicator_out),
    .led3_out(led3_out), .mode_four_out(mode_four_out));
`default_nettype wire

// ### verification/nsl_lamp_model.sv
// Purpose: Board indicator lamps
// Assumes: Lamp lit while driven high
// Notes: No timing of its own
`timescale 1ns/10ps
`default_nettype none
module nsl_lamp_model (
    input wire logic [3:0] drive_in,
    output logic [3:0] lit_out
);
    assign lit_out = drive_in;
endmodule // nsl_lamp_model
`default_nettype wire

// ### verification/network_status_led_driver_tb_top.sv
// Purpose: Lamp driver bench
// Assumes: Run far shorter than one blink half period, so blinking lamps stay dark
// Notes: Random status from xorshift seeded at 97
`timescale 1ns/10ps
`default_nettype none
module network_status_led_driver_tb_top;
    logic clk_in = 1'h0, reset_in = 1'h1, mode = 1'h0, link = 1'h0, spd = 1'h0, fdx = 1'h0;
    logic rx = 1'h0, tx = 1'h0, col = 1'h0, l0, l1, dci, l3, m4;
    logic [3:0] lit;
    logic [31:0] seed = 32'h61;
    int num_errors = 0, comparisons = 0;
    nsl_led_driver u_dut (.clk_in(clk_in), .reset_in(reset_in), .four_led_mode_in(mode), .link_ok_in(link),
        .speed_100_in(spd), .full_duplex_in(fdx), .rx_active_in(rx), .tx_active_in(tx), .collision_in(col),
        .led0_out(l0), .led1_out(l1), .duplex_collision_indicator_out(dci), .led3_out(l3), .mode_four_out(m4));
    nsl_lamp_model u_lamps (.drive_in({l3, dci, l1, l0}), .lit_out(lit));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [3:0] lamps(input logic s, input logic l, input logic d);
        return {1'h0, d, l, s};
    endfunction
    function automatic logic [3:0] lamps4(input logic s, input logic l, input logic d);
        return {1'h0, d, l & ~s, l & s};
    endfunction
    task check(input logic [3:0] seen, input logic [3:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t lamps %h want %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task step;
        @(posedge clk_in);
        #1;
    endtask
    initial forever #25 clk_in = ~clk_in;
    initial begin
        #100000;
        num_errors++;
        stop_test;
    end
    initial begin
        repeat (20) @(posedge clk_in);
        #1 reset_in = 1'h0;
        for (int i = 0; i < 200; i++) begin
            seed = xs(seed);
            // Strap rests at three-lamp until the mode has been taken, then roams
            {mode, fdx, spd, link} = {seed[3] & (i > 7), seed[2:0]};
            step;
            check(lit, lamps(spd, link, fdx));
            check({m4, 3'h0}, 4'h0);
        end
        $display("test steady done");
        // Trigger once, then lamp must stay dark for the first 100 cycles of the hold
        for (int t = 0; t < 2; t++) begin
            step;
            link = 1'h1;
            fdx = 1'h1;
            seed = xs(seed);
            rx = (t == 0) & seed[4];
            tx = (t == 0) & ~seed[4];
            col = (t == 1);
            repeat (100) begin
                step;
                check(lit, lamps(spd, 1'h0, t == 0));
                {rx, tx, col} = 3'h0;
                seed = xs(seed);
                spd = seed[0];
            end
            $display("test blink %0d done", t);
        end
        // Second reset in mid-run, strap now at four-lamp
        step;
        {rx, tx, col, link, spd, fdx} = 6'h00;
        mode = 1'h1;
        reset_in = 1'h1;
        repeat (4) step;
        reset_in = 1'h0;
        repeat (8) begin
            step;
            check(lit, 4'h0);
        end
        for (int i = 0; i < 200; i++) begin
            seed = xs(seed);
            {mode, fdx, spd, link} = seed[3:0];
            step;
            check(lit, lamps4(spd, link, fdx));
            check({m4, 3'h0}, 4'h8);
        end
        $display("test four steady done");
        for (int t = 0; t < 2; t++) begin
            step;
            fdx = 1'h1;
            seed = xs(seed);
            rx = (t == 0) & seed[4];
            tx = (t == 0) & ~seed[4];
            col = (t == 1);
            repeat (100) begin
                step;
                check(lit, lamps4(spd, link, t == 0));
                {rx, tx, col} = 3'h0;
                seed = xs(seed);
                {spd, link} = seed[1:0];
            end
            $display("test four blink %0d done", t);
        end
        stop_test;
    end
endmodule // network_status_led_driver_tb_top
`default_nettype wire
